// ### src/fdc_pkg.sv
// Constants and types for the four-channel transfer controller.
// Assumes a single 100 MHz clock and synchronous active-high reset.
// Contract
// RL1: Four channels, separate request and grant.
// RL2: Unmasked request asks host for bus.
// RL3: Raise bus request on valid request.
// RL4: On grant, acknowledge highest-priority channel only.
// RL5: Low address byte on address pins.
// RL6: Upper byte on data pins when changed.
// RL7: Strobes only after address presented.
// RL8: IO read pulses, floats cascade, idle input.
// RL9: IO write pulses, floats cascade, idle input.
// RL10: Memory read pulses, floats otherwise.
// RL11: Memory write pulses, floats otherwise.
// RL12: Ready low stretches transfer, strobes held.
// RL13: Host keeps ready stable near edge.
// RL14: Chip select ignored while grant high.
// RL15: Host waits a clock before granting.
// RL16: Latch pulse high with upper byte only.
// RL17: Address enable high while outputs valid.
// RL18: Host drives chip select low for access.
// RL19: Reset returns controller to initial state.
// RL20: Per channel enable, autoinit, direction.
// RL21: Request and grant polarity programmable.
// RL22: Done line reports end, external forces end.
// RL23: Four states per word, three skipping.
// RL24: Reset: requests high-active, grants low-active.
// RL25: Count exhaustion pulses done line low.
// RL26: Fixed priority, channel 0 highest.
// RL27: Everything sequenced from master clock.
package fdc_pkg;
  localparam int NUM_CH = 4;
  localparam int AW     = 16;
  localparam int CW     = 16;
  // Transfer types
  localparam logic [1:0] XFER_VERIFY = 2'h0;
  localparam logic [1:0] XFER_WRITE  = 2'h1;
  localparam logic [1:0] XFER_READ   = 2'h2;
  // Reset polarities: requests active high, grants active low
  localparam logic REQ_POL_RESET = 1'h1;
  localparam logic ACK_POL_RESET = 1'h0;
  // Least cycles between bus request rise and grant rise
  localparam int HOLD_GAP_NS  = 10;
  localparam int CLK_NS       = 10;
  localparam int HOLD_GAP_CYC = (HOLD_GAP_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_S0   = 3'b001,
    ST_S1   = 3'b010,
    ST_S2   = 3'b011,
    ST_S3   = 3'b100,
    ST_S4   = 3'b101
  } fdc_state_t;
endpackage

// ### src/fdc_arb.sv
// Fixed-priority grant picker for the four request lines.
// Assumes requests already polarity-corrected and masked.
`timescale 1ns/1ns
`default_nettype none
module fdc_arb
  import fdc_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Requests and choice
  input  wire logic [NUM_CH-1:0] req,
  output logic      [NUM_CH-1:0] pick_q
);
  logic [NUM_CH-1:0] pick_d;

  // RL26 lowest index wins
  always_comb
  begin
    pick_d = '0;
    for (int i = NUM_CH - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        pick_d = '0;
        pick_d[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      pick_q <= '0;
    else
      pick_q <= pick_d;
  end

  chk_fixed_prio_zero: // RL26
    assert property (@(posedge clk) disable iff (reset)
      req[0] |=> pick_q == 4'h1)
    else $error("channel 0 not preferred");
endmodule
`default_nettype wire

// ### src/fdc_top.sv
// Four-channel transfer controller bus sequencer.
// Assumes synchronous inputs, one clock, host grants the bus on request.
`timescale 1ns/1ns
`default_nettype none
module fdc_top
  import fdc_pkg::*;
(
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET,
  // Configuration
  input  wire logic [NUM_CH-1:0] CH_ENABLE,
  input  wire logic [NUM_CH-1:0] CH_AUTOINIT,
  input  wire logic [NUM_CH-1:0] CH_DECREMENT,
  input  wire logic [NUM_CH-1:0] CH_CASCADE,
  input  wire logic [2*NUM_CH-1:0] CH_XFER_TYPE,
  input  wire logic [NUM_CH*AW-1:0] CH_BASE_ADDR,
  input  wire logic [NUM_CH*CW-1:0] CH_BASE_COUNT,
  input  wire logic              LOAD_CH,
  input  wire logic              SET_POLARITY,
  input  wire logic              REQ_ACTIVE_LOW,
  input  wire logic              ACK_ACTIVE_HIGH,
  // Peripheral handshake
  input  wire logic [NUM_CH-1:0] CHANNEL_REQUEST,
  output logic      [NUM_CH-1:0] CHANNEL_GRANT,
  // Host hold handshake
  output logic                   BUS_REQUEST_OUT,
  input  wire logic              BUS_GRANT_IN,
  input  wire logic              READY,
  input  wire logic              CS_N,
  // Address and latch
  output logic      [7:0]        LOW_ADDR_PINS_O,
  output logic                   LOW_ADDR_PINS_OE,
  output logic      [7:0]        DATA_PINS_O,
  output logic                   DATA_PINS_OE,
  output logic                   UPPER_ADDR_LATCH_PULSE,
  output logic                   ADDR_DRIVE_VALID,
  // Strobes, active low
  input  wire logic              IO_READ_STROBE_N_I,
  output logic                   IO_READ_STROBE_N_O,
  output logic                   IO_READ_STROBE_OE,
  input  wire logic              IO_WRITE_STROBE_N_I,
  output logic                   IO_WRITE_STROBE_N_O,
  output logic                   IO_WRITE_STROBE_OE,
  output logic                   MEMORY_READ_STROBE_N_O,
  output logic                   MEMORY_READ_STROBE_OE,
  output logic                   MEMORY_WRITE_STROBE_N_O,
  output logic                   MEMORY_WRITE_STROBE_OE,
  // Done line, open drain
  input  wire logic              TRANSFER_DONE_LINE_N_I,
  output logic                   TRANSFER_DONE_LINE_OE,
  // Register access seen by host
  output logic                   REG_READ_SEL,
  output logic                   REG_WRITE_SEL,
  output logic [NUM_CH-1:0]      CH_TC_SEEN
);
  import fdc_pkg::*;

  fdc_state_t state_q, state_d;
  logic [NUM_CH-1:0] mask_q, mask_d, act_q, act_d, tc_q, tc_d;
  logic [AW-1:0] addr_q [NUM_CH];
  logic [AW-1:0] addr_d [NUM_CH];
  logic [CW-1:0] cnt_q [NUM_CH];
  logic [CW-1:0] cnt_d [NUM_CH];
  logic req_pol_q, req_pol_d, ack_pol_q, ack_pol_d;
  logic [7:0] hi_q, hi_d;
  logic hi_valid_q, hi_valid_d;
  logic [NUM_CH-1:0] req_eff, pick;
  logic [NUM_CH-1:0] grant_d;
  logic [1:0] ch_d, ch_q;
  logic [1:0] gap_q, gap_d;
  logic brq_d, aen_d, stb_d, ior_d, iow_d, mr_d, mw_d, ior_oe_d, iow_oe_d;
  logic mr_oe_d, mw_oe_d, a_oe_d, db_oe_d, eop_d, rsel_d, wsel_d;
  logic [7:0] a_d, db_d;
  logic [1:0] xt;
  logic casc, last, ext_end, stretch;
  logic [AW-1:0] next_addr;

  function automatic logic [1:0] enc(input logic [NUM_CH-1:0] one);
    enc = one[1] ? 2'h1 : one[2] ? 2'h2 : one[3] ? 2'h3 : 2'h0;
  endfunction

  // RL21 polarity-corrected requests, RL2 masking
  assign req_eff = (CHANNEL_REQUEST ^ {NUM_CH{~req_pol_q}}) & CH_ENABLE & ~mask_q;

  // RL1 RL4 priority pick
  fdc_arb u_arb
  (
    .clk    (CLK),
    .reset  (RESET),
    .req    (req_eff),
    .pick_q (pick)
  );

  assign xt = CH_XFER_TYPE[2*ch_q +: 2];
  assign casc = CH_CASCADE[ch_q];
  assign last = cnt_q[ch_q] == '0;
  assign ext_end = ~TRANSFER_DONE_LINE_N_I & ~casc;
  assign stretch = ~READY & (xt != XFER_VERIFY) & ~casc;
  assign next_addr = CH_DECREMENT[ch_q] ? addr_q[ch_q] - 1'b1 : addr_q[ch_q] + 1'b1;

  always_comb
  begin
    state_d = state_q;
    mask_d = mask_q;
    act_d = act_q;
    tc_d = tc_q;
    addr_d = addr_q;
    cnt_d = cnt_q;
    req_pol_d = req_pol_q;
    ack_pol_d = ack_pol_q;
    hi_d = hi_q;
    hi_valid_d = hi_valid_q;
    ch_d = ch_q;
    gap_d = gap_q;
    // RL20 load base values per channel
    if (LOAD_CH && state_q == ST_IDLE)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        addr_d[i] = CH_BASE_ADDR[i*AW +: AW];
        cnt_d[i] = CH_BASE_COUNT[i*CW +: CW];
      end
      mask_d = '0;
      tc_d = '0;
    end
    // RL21 polarity update
    if (SET_POLARITY && state_q == ST_IDLE)
    begin
      req_pol_d = ~REQ_ACTIVE_LOW;
      ack_pol_d = ACK_ACTIVE_HIGH;
    end
    case (state_q)
      ST_IDLE:
      begin
        // RL3 request bus
        if (|req_eff)
        begin
          state_d = ST_S0;
          gap_d = '0;
        end
      end
      ST_S0:
      begin
        if (gap_q != 2'h3)
          gap_d = gap_q + 2'h1;
        if (BUS_GRANT_IN)
        begin
          ch_d = enc(pick);
          act_d = pick;
          hi_valid_d = 1'b0;
          state_d = (|pick) ? ST_S1 : ST_IDLE;
        end
      end
      ST_S1:
      begin
        hi_d = addr_q[ch_q][AW-1:8];
        hi_valid_d = 1'b1;
        state_d = casc ? ST_S1 : ST_S2;
        if (casc && !req_eff[ch_q])
        begin
          act_d = '0;
          state_d = ST_IDLE;
        end
      end
      ST_S2:
        state_d = ST_S3;
      ST_S3:
      begin
        // RL12 wait while not ready
        if (!stretch)
          state_d = ST_S4;
      end
      ST_S4:
      begin
        addr_d[ch_q] = next_addr;
        cnt_d[ch_q] = cnt_q[ch_q] - 1'b1;
        act_d = '0;
        state_d = ST_IDLE;
        // RL22 RL25 terminal count or forced end
        if (last || ext_end)
        begin
          tc_d[ch_q] = 1'b1;
          if (CH_AUTOINIT[ch_q])
          begin
            addr_d[ch_q] = CH_BASE_ADDR[ch_q*AW +: AW];
            cnt_d[ch_q] = CH_BASE_COUNT[ch_q*CW +: CW];
          end
          else
            mask_d[ch_q] = 1'b1;
        end
        else if (req_eff[ch_q])
        begin
          // RL23 skip S1 when upper byte unchanged
          act_d = act_q;
          state_d = (next_addr[AW-1:8] == hi_q) ? ST_S2 : ST_S1;
        end
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  // Output next values
  always_comb
  begin
    grant_d = {NUM_CH{~ack_pol_d}};
    brq_d = state_d != ST_IDLE;
    aen_d = state_d inside {ST_S1, ST_S2, ST_S3, ST_S4} && !CH_CASCADE[ch_d];
    stb_d = state_d == ST_S1 && !CH_CASCADE[ch_d];
    a_oe_d = aen_d;
    db_oe_d = stb_d;
    a_d = addr_d[ch_d][7:0];
    db_d = addr_d[ch_d][AW-1:8];
    ior_d = 1'b1;
    iow_d = 1'b1;
    mr_d = 1'b1;
    mw_d = 1'b1;
    // RL8 RL9 RL10 RL11 drive only in non-cascade transfers
    ior_oe_d = aen_d;
    iow_oe_d = aen_d;
    mr_oe_d = aen_d;
    mw_oe_d = aen_d;
    eop_d = state_q == ST_S4 && state_d != ST_S2 && state_d != ST_S1 && last && !casc;
    // RL14 chip select masked while granted
    rsel_d = !CS_N && !BUS_GRANT_IN && !IO_READ_STROBE_N_I && state_q == ST_IDLE;
    wsel_d = !CS_N && !BUS_GRANT_IN && !IO_WRITE_STROBE_N_I && state_q == ST_IDLE;
    for (int i = 0; i < NUM_CH; i++)
      if (act_d[i])
        grant_d[i] = ack_pol_d;
    // RL7 strobes follow address states
    if (state_d inside {ST_S2, ST_S3} || (state_d == ST_S4 && state_q == ST_S3))
    begin
      if (CH_XFER_TYPE[2*ch_d +: 2] == XFER_READ)
      begin
        mr_d = 1'b0;
        iow_d = state_d == ST_S2;
      end
      else if (CH_XFER_TYPE[2*ch_d +: 2] == XFER_WRITE)
      begin
        ior_d = 1'b0;
        mw_d = state_d == ST_S2;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    // RL19 RL24 RL27 synchronous reset to idle
    if (RESET)
    begin
      state_q <= ST_IDLE;
      mask_q <= '0;
      act_q <= '0;
      tc_q <= '0;
      req_pol_q <= REQ_POL_RESET;
      ack_pol_q <= ACK_POL_RESET;
      hi_q <= '0;
      hi_valid_q <= 1'b0;
      ch_q <= '0;
      gap_q <= '0;
      for (int i = 0; i < NUM_CH; i++)
      begin
        addr_q[i] <= '0;
        cnt_q[i] <= '0;
      end
      CHANNEL_GRANT <= {NUM_CH{~ACK_POL_RESET}};
      BUS_REQUEST_OUT <= 1'b0;
      ADDR_DRIVE_VALID <= 1'b0;
      UPPER_ADDR_LATCH_PULSE <= 1'b0;
      LOW_ADDR_PINS_O <= '0;
      LOW_ADDR_PINS_OE <= 1'b0;
      DATA_PINS_O <= '0;
      DATA_PINS_OE <= 1'b0;
      IO_READ_STROBE_N_O <= 1'b1;
      IO_READ_STROBE_OE <= 1'b0;
      IO_WRITE_STROBE_N_O <= 1'b1;
      IO_WRITE_STROBE_OE <= 1'b0;
      MEMORY_READ_STROBE_N_O <= 1'b1;
      MEMORY_READ_STROBE_OE <= 1'b0;
      MEMORY_WRITE_STROBE_N_O <= 1'b1;
      MEMORY_WRITE_STROBE_OE <= 1'b0;
      TRANSFER_DONE_LINE_OE <= 1'b0;
      REG_READ_SEL <= 1'b0;
      REG_WRITE_SEL <= 1'b0;
      CH_TC_SEEN <= '0;
    end
    else
    begin
      state_q <= state_d;
      mask_q <= mask_d;
      act_q <= act_d;
      tc_q <= tc_d;
      req_pol_q <= req_pol_d;
      ack_pol_q <= ack_pol_d;
      hi_q <= hi_d;
      hi_valid_q <= hi_valid_d;
      ch_q <= ch_d;
      gap_q <= gap_d;
      addr_q <= addr_d;
      cnt_q <= cnt_d;
      CHANNEL_GRANT <= grant_d;
      BUS_REQUEST_OUT <= brq_d;
      // RL17 address enable with valid outputs
      ADDR_DRIVE_VALID <= aen_d;
      // RL6 RL16 upper byte latch pulse
      UPPER_ADDR_LATCH_PULSE <= stb_d;
      // RL5 low byte on address pins
      LOW_ADDR_PINS_O <= a_d;
      LOW_ADDR_PINS_OE <= a_oe_d;
      DATA_PINS_O <= db_d;
      DATA_PINS_OE <= db_oe_d;
      IO_READ_STROBE_N_O <= ior_d;
      IO_READ_STROBE_OE <= ior_oe_d;
      IO_WRITE_STROBE_N_O <= iow_d;
      IO_WRITE_STROBE_OE <= iow_oe_d;
      MEMORY_READ_STROBE_N_O <= mr_d;
      MEMORY_READ_STROBE_OE <= mr_oe_d;
      MEMORY_WRITE_STROBE_N_O <= mw_d;
      MEMORY_WRITE_STROBE_OE <= mw_oe_d;
      TRANSFER_DONE_LINE_OE <= eop_d;
      REG_READ_SEL <= rsel_d;
      REG_WRITE_SEL <= wsel_d;
      CH_TC_SEEN <= tc_d;
    end
  end

  sequence s_addr_then_strobe;
    ADDR_DRIVE_VALID ##1 !MEMORY_READ_STROBE_N_O;
  endsequence

  chk_req_raises_hold: // RL3
    assert property (@(posedge CLK) disable iff (RESET)
      state_q == ST_IDLE && |req_eff |=> BUS_REQUEST_OUT)
    else $error("bus request not raised");
  chk_hold_on_pending: // RL2
    assert property (@(posedge CLK) disable iff (RESET)
      state_q == ST_S0 |-> BUS_REQUEST_OUT)
    else $error("bus request dropped while waiting");
  chk_strobe_after_addr: // RL7
    assert property (@(posedge CLK) disable iff (RESET)
      $fell(MEMORY_READ_STROBE_N_O) |-> $past(ADDR_DRIVE_VALID) && ADDR_DRIVE_VALID)
    else $error("strobe before address");
  chk_cs_masked_grant: // RL14
    assert property (@(posedge CLK) disable iff (RESET)
      $past(BUS_GRANT_IN) |-> !REG_READ_SEL && !REG_WRITE_SEL)
    else $error("register access during grant");
  chk_latch_pulse_data: // RL16
    assert property (@(posedge CLK) disable iff (RESET)
      UPPER_ADDR_LATCH_PULSE |-> DATA_PINS_OE && ADDR_DRIVE_VALID)
    else $error("latch pulse without upper byte");
  chk_strobes_float_idle: // RL10
    assert property (@(posedge CLK) disable iff (RESET)
      !ADDR_DRIVE_VALID |-> !MEMORY_READ_STROBE_OE && !MEMORY_WRITE_STROBE_OE)
    else $error("memory strobe driven while idle");
  chk_ready_stretch: // RL12
    assert property (@(posedge CLK) disable iff (RESET)
      state_q == ST_S3 && stretch |=> state_q == ST_S3)
    else $error("ready low not honoured");
  chk_single_grant: // RL4
    assert property (@(posedge CLK) disable iff (RESET)
      $onehot0(act_q))
    else $error("more than one channel granted");
  chk_done_pulse_one: // RL25
    assert property (@(posedge CLK) disable iff (RESET)
      TRANSFER_DONE_LINE_OE |=> !TRANSFER_DONE_LINE_OE)
    else $error("done pulse too long");
  chk_reset_polarity: // RL24
    assert property (@(posedge CLK)
      $past(RESET) && RESET |-> CHANNEL_GRANT == 4'hf)
    else $error("grant not inactive-high after reset");
endmodule
`default_nettype wire

// ### sim/fdc_host_model.sv
// Host side of the hold handshake: grants the bus after a set gap.
// Assumes the controller's clock and synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module fdc_host_model
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Hold handshake
  input  wire logic [3:0] gap,
  input  wire logic       bus_request,
  output var  logic       bus_grant
);
  logic [3:0] wait_q;

  always_ff @(posedge clk)
  begin
    if (reset || !bus_request)
    begin
      wait_q    <= 4'h0;
      bus_grant <= 1'b0;
    end
    else if (wait_q < gap)
      wait_q <= wait_q + 4'h1;
    else
      bus_grant <= 1'b1;
  end
endmodule
`default_nettype wire

// ### sim/fdc_top_tb.sv
// Bench: word transfers of each type, priority, polarity and register selects.
// Assumes the host model for the hold handshake; strobe and done lines pulled high.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module fdc_top_tb;
  import fdc_pkg::*;
  logic                 CLK, RESET, LOAD_CH, SET_POLARITY, REQ_ACTIVE_LOW, ACK_ACTIVE_HIGH, READY, CS_N;
  logic                 io_rd_n, io_wr_n, got, pb, mon, breq, bgnt, addr_drive_valid, upper_addr_latch_pulse, lo_oe, db_oe, done_oe;
  logic                 rsel, wsel, ior_o, ior_oe, iow_o, iow_oe, mr_o, mr_oe, mw_o, mw_oe, rd_low, wr_low;
  logic [NUM_CH-1:0]    en, ai, dec, cas, req, grant, tc, first_grant, seen, idle_g;
  logic [2*NUM_CH-1:0]  xt;
  logic [NUM_CH*AW-1:0] base;
  logic [NUM_CH*CW-1:0] cnt;
  logic [7:0]           lo_a, db, last_up, last_lo;
  logic [3:0]           gap;
  int                   num_errors, compares, rd_lo, wr_lo, n_stb, n_done, bad, waits;

  assign rd_low = (ior_oe & ~ior_o) | (mr_oe & ~mr_o);
  assign wr_low = (iow_oe & ~iow_o) | (mw_oe & ~mw_o);
  assign idle_g = ACK_ACTIVE_HIGH ? 4'h0 : 4'hf;

  fdc_top i_fdc_top (.CLK(CLK), .RESET(RESET), .CH_ENABLE(en), .CH_AUTOINIT(ai), .CH_DECREMENT(dec),
    .CH_CASCADE(cas), .CH_XFER_TYPE(xt), .CH_BASE_ADDR(base), .CH_BASE_COUNT(cnt), .LOAD_CH(LOAD_CH),
    .SET_POLARITY(SET_POLARITY), .REQ_ACTIVE_LOW(REQ_ACTIVE_LOW), .ACK_ACTIVE_HIGH(ACK_ACTIVE_HIGH),
    .CHANNEL_REQUEST(req), .CHANNEL_GRANT(grant), .BUS_REQUEST_OUT(breq), .BUS_GRANT_IN(bgnt),
    .READY(READY), .CS_N(CS_N), .LOW_ADDR_PINS_O(lo_a), .LOW_ADDR_PINS_OE(lo_oe), .DATA_PINS_O(db),
    .DATA_PINS_OE(db_oe), .UPPER_ADDR_LATCH_PULSE(upper_addr_latch_pulse), .ADDR_DRIVE_VALID(addr_drive_valid),
    .IO_READ_STROBE_N_I(ior_oe ? ior_o : io_rd_n), .IO_READ_STROBE_N_O(ior_o), .IO_READ_STROBE_OE(ior_oe),
    .IO_WRITE_STROBE_N_I(iow_oe ? iow_o : io_wr_n), .IO_WRITE_STROBE_N_O(iow_o),
    .IO_WRITE_STROBE_OE(iow_oe), .MEMORY_READ_STROBE_N_O(mr_o), .MEMORY_READ_STROBE_OE(mr_oe),
    .MEMORY_WRITE_STROBE_N_O(mw_o), .MEMORY_WRITE_STROBE_OE(mw_oe), .TRANSFER_DONE_LINE_N_I(~done_oe),
    .TRANSFER_DONE_LINE_OE(done_oe), .REG_READ_SEL(rsel), .REG_WRITE_SEL(wsel), .CH_TC_SEEN(tc));

  fdc_host_model i_fdc_host_model (.clk(CLK), .reset(RESET), .gap(gap), .bus_request(breq), .bus_grant(bgnt));

  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // Watches each transfer; stretches the strobes with ready when asked
  always @(posedge CLK)
  begin
    if (mon)
    begin
      rd_lo += rd_low;
      wr_lo += wr_low;
      n_done += done_oe;
      seen |= {ior_oe & ~ior_o, iow_oe & ~iow_o, mr_oe & ~mr_o, mw_oe & ~mw_o};
      if ((rd_low || wr_low) && !(addr_drive_valid && lo_oe))
        bad++;
      if (pb && (rsel || wsel))
        bad++;
      if (upper_addr_latch_pulse)
        last_up = db;
      n_stb += (upper_addr_latch_pulse && db_oe);
      if (addr_drive_valid && lo_oe)
        last_lo = lo_a;
      if (!got && grant !== idle_g)
      begin
        first_grant = grant;
        got = 1'b1;
      end
      // ready low, set 1 ns after rising edge
      if (waits > 0 && rd_low)
      begin
        READY <= #1 1'b0;
        waits--;
      end
      else
        READY <= #1 1'b1;
    end
    pb = bgnt;
  end

  task automatic tick();
    @(posedge CLK);
    #1;
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic xfer(input int ch, input logic [1:0] typ, input logic [15:0] a, input logic [15:0] c,
                      input logic d, input int nw, input logic [3:0] m);
    int i;
    base[ch*AW +: AW] = a;
    cnt[ch*CW +: CW] = c;
    xt[2*ch +: 2] = typ;
    dec[ch] = d;
    LOAD_CH = 1'b1;
    tick();
    LOAD_CH = 1'b0;
    {rd_lo, wr_lo, n_stb, n_done, bad} = '0;
    seen = 4'h0;
    got = 1'b0;
    waits = nw;
    mon = 1'b1;
    CS_N = 1'b0;
    io_rd_n = 1'b0;
    req = REQ_ACTIVE_LOW ? ~m : m;
    for (i = 0; i < 400 && !((tc & m) == m && !breq); i++)
      tick();
    if (i == 400)
    begin
      num_errors++;
      $display("[FAIL] transfer timeout");
      test_done();
    end
    tick();
    tick();
    mon = 1'b0;
    CS_N = 1'b1;
    io_rd_n = 1'b1;
    req = REQ_ACTIVE_LOW ? 4'hf : 4'h0;
    tick();
  endtask

  task automatic chk_word(input logic [3:0] se, input int rd, input int wr, input int stb, input logic [7:0] up,
                          input logic [7:0] lo);
    `CHK("strobes used", se, seen)
    `CHK("read low cycles", rd, rd_lo)
    `CHK("write low cycles", wr, wr_lo)
    `CHK("latch pulses", stb, n_stb)
    `CHK("upper byte", up, last_up)
    `CHK("low byte", lo, last_lo)
    `CHK("done pulses", 1, n_done)
    `CHK("strobe order", 0, bad)
  endtask

  task automatic chk_idle();
    `CHK("idle outputs", {4'hf, 8'h00}, {grant, breq, addr_drive_valid, upper_addr_latch_pulse, mr_oe, mw_oe, ior_oe, iow_oe, db_oe})
  endtask

  initial
  begin
    {RESET, LOAD_CH, SET_POLARITY, REQ_ACTIVE_LOW, ACK_ACTIVE_HIGH, mon} = 6'h20;
    {READY, CS_N, io_rd_n, io_wr_n} = 4'hf;
    {en, ai, dec, cas, req} = {4'hf, 16'h0};
    {xt, base, cnt} = '0;
    {num_errors, compares, waits} = '0;
    pb = 1'b0;
    gap = 4'h2;
    repeat (16) tick();
    RESET = 1'b0;
    tick();
    chk_idle();
    // Idle register selects
    CS_N = 1'b0;
    io_rd_n = 1'b0;
    tick();
    tick();
    `CHK("read select", 1'b1, rsel)
    io_rd_n = 1'b1;
    io_wr_n = 1'b0;
    tick();
    tick();
    `CHK("write select", 1'b1, wsel)
    io_wr_n = 1'b1;
    CS_N = 1'b1;
    tick();
    xfer(0, XFER_WRITE, 16'h12ff, 16'h0001, 1'b0, 0, 4'h1);
    chk_word(4'b1001, 6, 4, 2, 8'h13, 8'h00);
    `CHK("first grant", 4'he, first_grant)
    gap = 4'h6;
    xfer(3, XFER_READ, 16'h4000, 16'h0001, 1'b1, 3, 4'h8);
    chk_word(4'b0110, 9, 7, 2, 8'h3f, 8'hff);
    xfer(2, XFER_VERIFY, 16'h0055, 16'h0000, 1'b0, 0, 4'h4);
    chk_word(4'b0000, 0, 0, 1, 8'h00, 8'h55);
    `CHK("sticky count", 4'h4, tc)
    xfer(1, XFER_WRITE, 16'h0100, 16'h0000, 1'b0, 0, 4'h6);
    `CHK("priority grant", 4'hd, first_grant)
    // Swap both polarities
    REQ_ACTIVE_LOW = 1'b1;
    ACK_ACTIVE_HIGH = 1'b1;
    req = 4'hf;
    en = 4'h0;
    SET_POLARITY = 1'b1;
    tick();
    SET_POLARITY = 1'b0;
    en = 4'hf;
    tick();
    `CHK("high grant idle", 4'h0, grant)
    xfer(3, XFER_READ, 16'h0200, 16'h0000, 1'b0, 0, 4'h8);
    `CHK("high grant", 4'h8, first_grant)
    REQ_ACTIVE_LOW = 1'b0;
    ACK_ACTIVE_HIGH = 1'b0;
    req = 4'h0;
    RESET = 1'b1;
    tick();
    tick();
    RESET = 1'b0;
    tick();
    chk_idle();
    test_done();
  end
endmodule
`default_nettype wire
